// File: hdl/axt_axil.sv
// axi4-lite slave holding control, status and code registers
`timescale 1ns/1ps
`default_nettype none
module axt_axil (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// write channels
	input wire logic [3:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	// read channels
	input wire logic [3:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// block side
	output logic [1:0] o_ctrl,
	input wire logic [3:0] i_stat,
	input wire logic [6:0] i_code
);
	import axt_pkg::*;

	logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt, bvalid_r, bvalid_nxt;
	logic [3:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic wstrb0_r, wstrb0_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt, ctrl_r, ctrl_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic do_wr;
	logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;

	// write path: take address and data in either order, answer after both
	always_comb begin
		aw_have_nxt = aw_have_r;
		w_have_nxt = w_have_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb0_nxt = wstrb0_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		ctrl_nxt = ctrl_r;
		if (i_awvalid && !aw_have_r && !bvalid_r) begin
			aw_have_nxt = 1'b1;
			awaddr_nxt = i_awaddr;
		end
		if (i_wvalid && !w_have_r && !bvalid_r) begin
			w_have_nxt = 1'b1;
			wdata_nxt = i_wdata;
			wstrb0_nxt = i_wstrb[0];
		end
		do_wr = aw_have_r && w_have_r && !bvalid_r;
		if (do_wr) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = AXT_RESP_OKAY;
			if (awaddr_r[3:2] == AXT_REG_CTRL[3:2]) begin
				if (wstrb0_r) begin
					ctrl_nxt = wdata_r[1:0];
				end
			end else if (awaddr_r[3:2] != AXT_REG_STAT[3:2] && awaddr_r[3:2] != AXT_REG_CODE[3:2]) begin
				bresp_nxt = AXT_RESP_SLVERR;
			end
		end
		if (bvalid_r && i_bready) begin
			bvalid_nxt = 1'b0;
		end
		// ready flags registered so the bus sees flop outputs
		awready_nxt = !aw_have_nxt && !bvalid_nxt;
		wready_nxt = !w_have_nxt && !bvalid_nxt;
	end

	// read path: one read in flight, answer the cycle after acceptance
	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (i_arvalid && !rvalid_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = AXT_RESP_OKAY;
			unique case (i_araddr[3:2])
				AXT_REG_CTRL[3:2]: rdata_nxt = {30'h0, ctrl_r};
				AXT_REG_STAT[3:2]: rdata_nxt = {28'h0, i_stat};
				AXT_REG_CODE[3:2]: rdata_nxt = {25'h0, i_code};
				default: begin
					rdata_nxt = 32'h0;
					rresp_nxt = AXT_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && i_rready) begin
			rvalid_nxt = 1'b0;
		end
		arready_nxt = !rvalid_nxt;
	end

	// register bus state
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= 4'h0;
			wdata_r <= 32'h0;
			wstrb0_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
			ctrl_r <= AXT_CTRL_RST;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= 2'h0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			arready_r <= 1'b1;
		end else begin
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb0_r <= wstrb0_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			ctrl_r <= ctrl_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			arready_r <= arready_nxt;
		end
	end

	assign o_awready = awready_r;
	assign o_wready = wready_r;
	assign o_bvalid = bvalid_r;
	assign o_bresp = bresp_r;
	assign o_arready = arready_r;
	assign o_rvalid = rvalid_r;
	assign o_rdata = rdata_r;
	assign o_rresp = rresp_r;
	assign o_ctrl = ctrl_r;
endmodule
`default_nettype wire

// File: hdl/axt_ctrl.sv
// top of the i2c address xor translator control logic
// Functional notes
// - sample config at reset and enable rise
// - low code sets bits a3 to a0
// - high code sets bits a6 to a4
// - low quantizer gives sixteen band codes
// - high quantizer gives eight band codes
// - byte form puts zero in lsb
// - switches and ready wait enable, config, then stop, idle or pass-through
// - switches open right after power-up
// - disable or undervoltage clears code, opens all
// - pass-through flag keeps switches closed
// - pass-through aborts a running translation
// - step shift register during clock low
// - xor seven address bits, then reconnect
// - thirty millisecond stuck clock aborts translation
`timescale 1ns/1ps
`default_nettype none
module axt_ctrl (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// quantized configuration inputs
	input wire logic [axt_pkg::AXT_LO_W-1:0] i_low_nibble_config,
	input wire logic [axt_pkg::AXT_HI_W-1:0] i_high_bits_config,
	input wire logic i_pass_through,
	input wire logic i_enable,
	input wire logic i_supply_undervoltage_flag,
	// bus line levels sensed
	input wire logic i_master_clock_line,
	input wire logic i_master_data_line,
	input wire logic i_slave_clock_line,
	input wire logic i_slave_data_line,
	// switch and driver controls
	output logic o_clock_pass_switch,
	output logic o_data_pass_switch,
	output logic o_data_pulldown_driver,
	output logic o_ready,
	output logic [7:0] o_code_byte,
	// axi4-lite register bus
	input wire logic [3:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [3:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready
);
	import axt_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	// translation bit for a given step, most significant first
	function automatic logic xor_bit(input logic [AXT_CODE_W-1:0] code, input logic [2:0] step);
		logic [2:0] idx;
		idx = 3'(AXT_CODE_W - 1) - step;
		return code[idx];
	endfunction

	// ****************************************
	// input synchronisers
	// ****************************************
	localparam int SW = 4 + AXT_LO_W + AXT_HI_W + 3;
	logic [SW-1:0] sync_out;
	logic [1:0] ctrl_bits;
	logic en_s, uv_s, pass_s, scl_s, sda_s, sclo_s, sdao_s;
	logic [AXT_LO_W-1:0] lo_s;
	logic [AXT_HI_W-1:0] hi_s;

	axt_sync #(.W(SW)) axt_sync_inst (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_async({i_enable, i_supply_undervoltage_flag, i_pass_through, i_low_nibble_config,
			i_high_bits_config, i_master_clock_line, i_master_data_line,
			i_slave_clock_line, i_slave_data_line}),
		.o_sync(sync_out)
	);
	assign {en_s, uv_s, pass_s, lo_s, hi_s, scl_s, sda_s, sclo_s, sdao_s} = sync_out;

	// ****************************************
	// register bus
	// ****************************************
	logic [3:0] stat;
	logic [AXT_CODE_W-1:0] code_r, code_nxt;
	axt_axil axt_axil_inst (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid),
		.o_awready(o_awready),
		.i_wdata(i_wdata),
		.i_wstrb(i_wstrb),
		.i_wvalid(i_wvalid),
		.o_wready(o_wready),
		.o_bresp(o_bresp),
		.o_bvalid(o_bvalid),
		.i_bready(i_bready),
		.i_araddr(i_araddr),
		.i_arvalid(i_arvalid),
		.o_arready(o_arready),
		.o_rdata(o_rdata),
		.o_rresp(o_rresp),
		.o_rvalid(o_rvalid),
		.i_rready(i_rready),
		.o_ctrl(ctrl_bits),
		.i_stat(stat),
		.i_code(code_r)
	);

	// ****************************************
	// translator state
	// ****************************************
	axt_state_t state_r, state_nxt;
	logic pass_r, pass_nxt;
	logic cfg_r, cfg_nxt;
	logic en_d_r, en_d_nxt, scl_d_r, scl_d_nxt, sda_d_r, sda_d_nxt;
	logic [2:0] bit_r, bit_nxt;
	logic [AXT_CNT_W-1:0] idle_r, idle_nxt, stuck_r, stuck_nxt;
	logic [7:0] step_r, step_nxt;
	logic stepping_r, stepping_nxt;
	logic xbit_r, xbit_nxt;
	logic cps_r, cps_nxt, dps_r, dps_nxt, pd_r, pd_nxt, rdy_r, rdy_nxt;
	logic en_act, start_c, stop_c, en_rise, scl_fall, scl_edge, all_high;

	// bus condition decode
	always_comb begin
		en_act = (en_s | ctrl_bits[AXT_CTRL_EN_BIT]) & ~uv_s & ~ctrl_bits[AXT_CTRL_UV_BIT];
		en_rise = en_act & ~en_d_r;
		start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
		stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
		scl_fall = scl_d_r & ~scl_s;
		scl_edge = scl_d_r ^ scl_s;
		all_high = scl_s & sda_s & sclo_s & sdao_s;
	end

	// next state of the translator
	always_comb begin
		state_nxt = state_r;
		code_nxt = code_r;
		pass_nxt = pass_r;
		cfg_nxt = cfg_r;
		en_d_nxt = en_act;
		scl_d_nxt = scl_s;
		sda_d_nxt = sda_s;
		bit_nxt = bit_r;
		idle_nxt = idle_r;
		stuck_nxt = stuck_r;
		step_nxt = step_r;
		stepping_nxt = stepping_r;
		xbit_nxt = xbit_r;
		// counters saturate so a long quiet spell never wraps below a limit
		if (!all_high) begin
			idle_nxt = '0;
		end else if (idle_r != '1) begin
			idle_nxt = idle_r + 1'b1;
		end
		if (scl_edge) begin
			stuck_nxt = '0;
		end else if (stuck_r != '1) begin
			stuck_nxt = stuck_r + 1'b1;
		end
		if (!en_act) begin
			// shut down: clear code, open everything
			state_nxt = AXT_OFF;
			code_nxt = AXT_CODE_RST;
			cfg_nxt = 1'b0;
			stepping_nxt = 1'b0;
		end else if (en_rise || (state_r == AXT_OFF)) begin
			// latch quantized codes into the translation word
			code_nxt = {hi_s, lo_s};
			pass_nxt = pass_s;
			cfg_nxt = 1'b1;
			state_nxt = AXT_WAIT_IDLE;
		end else begin
			pass_nxt = pass_s;
			unique case (state_r)
				AXT_WAIT_IDLE: begin
					// wait for stop, long all-high idle or pass-through
					if (pass_s || stop_c || idle_r > AXT_CNT_W'(AXT_IDLE_CYC)) begin
						state_nxt = AXT_RUN;
					end
				end
				AXT_RUN: begin
					if (start_c && !pass_s) begin
						state_nxt = AXT_XLATE;
						bit_nxt = 3'd0;
						// no inversion before the first clock fall, so the start passes intact
						xbit_nxt = 1'b0;
						stepping_nxt = 1'b0;
						// a long quiet spell before the start must not count as stuck
						stuck_nxt = '0;
					end
				end
				AXT_XLATE: begin
					if (pass_s || stop_c || stuck_r > AXT_CNT_W'(AXT_STUCK_CYC)) begin
						state_nxt = AXT_RUN;
					end else if (scl_fall) begin
						step_nxt = 8'd0;
						stepping_nxt = 1'b1;
					end else if (stepping_r) begin
						// step the register after the delay, clock still low
						if (step_r >= 8'(AXT_STEP_CYC)) begin
							stepping_nxt = 1'b0;
							if (!scl_s) begin
								if (bit_r == 3'(AXT_ADDR_BITS)) begin
									// fall before read/write: reconnect
									state_nxt = AXT_RUN;
								end else begin
									bit_nxt = bit_r + 3'd1;
									xbit_nxt = xor_bit(code_r, bit_r);
								end
							end
						end else begin
							step_nxt = step_r + 8'd1;
						end
					end
				end
				AXT_OFF: state_nxt = AXT_WAIT_IDLE;
			endcase
		end
	end

	// pin drive next values, outputs all from flops
	always_comb begin
		cps_nxt = 1'b0;
		dps_nxt = 1'b0;
		pd_nxt = 1'b0;
		rdy_nxt = 1'b0;
		if (state_nxt == AXT_RUN || state_nxt == AXT_XLATE) begin
			cps_nxt = 1'b1;
			dps_nxt = 1'b1;
			rdy_nxt = 1'b1;
		end
		if (state_nxt == AXT_XLATE) begin
			// pull slave data low when master bit xor translation bit is zero
			dps_nxt = 1'b0;
			pd_nxt = ~(sda_s ^ xbit_nxt);
		end
	end

	// register translator state
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			state_r <= AXT_OFF;
			code_r <= AXT_CODE_RST;
			pass_r <= 1'b0;
			cfg_r <= 1'b0;
			en_d_r <= 1'b0;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			bit_r <= 3'd0;
			idle_r <= '0;
			stuck_r <= '0;
			step_r <= 8'd0;
			stepping_r <= 1'b0;
			xbit_r <= 1'b0;
			cps_r <= 1'b0;
			dps_r <= 1'b0;
			pd_r <= 1'b0;
			rdy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			code_r <= code_nxt;
			pass_r <= pass_nxt;
			cfg_r <= cfg_nxt;
			en_d_r <= en_d_nxt;
			scl_d_r <= scl_d_nxt;
			sda_d_r <= sda_d_nxt;
			bit_r <= bit_nxt;
			idle_r <= idle_nxt;
			stuck_r <= stuck_nxt;
			step_r <= step_nxt;
			stepping_r <= stepping_nxt;
			xbit_r <= xbit_nxt;
			cps_r <= cps_nxt;
			dps_r <= dps_nxt;
			pd_r <= pd_nxt;
			rdy_r <= rdy_nxt;
		end
	end

	// status word and outputs
	assign stat = {pass_r, cfg_r, state_r == AXT_XLATE, rdy_r};
	assign o_clock_pass_switch = cps_r;
	assign o_data_pass_switch = dps_r;
	assign o_data_pulldown_driver = pd_r;
	assign o_ready = rdy_r;
	assign o_code_byte = {code_r, 1'b0};
endmodule
`default_nettype wire

// File: hdl/axt_pkg.sv
// package of constants and types for the i2c address xor translator control
package axt_pkg;
	// timing figures
	localparam int AXT_CLK_MHZ = 200;
	localparam int AXT_IDLE_US = 120;
	localparam int AXT_IDLE_CYC = AXT_IDLE_US * AXT_CLK_MHZ;
	localparam int AXT_STEP_NS = 100;
	localparam int AXT_STEP_CYC = (AXT_STEP_NS * AXT_CLK_MHZ) / 1000;
	localparam int AXT_STUCK_MS = 30;
	localparam int AXT_STUCK_CYC = AXT_STUCK_MS * 1000 * AXT_CLK_MHZ;
	localparam int AXT_CNT_W = 23;
	// code widths and reset values
	localparam int AXT_LO_W = 4;
	localparam int AXT_HI_W = 3;
	localparam int AXT_CODE_W = 7;
	localparam int AXT_ADDR_BITS = 7;
	localparam logic [6:0] AXT_CODE_RST = 7'h00;
	// register map
	localparam logic [3:0] AXT_REG_CTRL = 4'h0;
	localparam logic [3:0] AXT_REG_STAT = 4'h4;
	localparam logic [3:0] AXT_REG_CODE = 4'h8;
	localparam int AXT_CTRL_EN_BIT = 0;
	localparam int AXT_CTRL_UV_BIT = 1;
	localparam logic [1:0] AXT_CTRL_RST = 2'h0;
	localparam int AXT_STAT_RDY_BIT = 0;
	localparam int AXT_STAT_XLT_BIT = 1;
	localparam int AXT_STAT_CFG_BIT = 2;
	localparam int AXT_STAT_PASS_BIT = 3;
	localparam logic [1:0] AXT_RESP_OKAY = 2'h0;
	localparam logic [1:0] AXT_RESP_SLVERR = 2'h2;
	// translator states
	typedef enum logic [1:0] {AXT_OFF, AXT_WAIT_IDLE, AXT_RUN, AXT_XLATE} axt_state_t;
endpackage

// File: hdl/axt_sync.sv
// two-flop synchroniser for a group of external levels
`timescale 1ns/1ps
`default_nettype none
module axt_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// levels
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_r;
	logic [W-1:0] sync_nxt;

	// next values: first stage only feeds second
	always_comb begin
		meta_nxt = i_async;
		sync_nxt = meta_r;
	end

	// register both stages
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			meta_r <= '1;
			sync_r <= '1;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign o_sync = sync_r;
endmodule
`default_nettype wire

// File: testbench/axt_bus_model.sv
// behavioural bus master and slave-side wiring
`timescale 1ns/1ps
`default_nettype none
module axt_bus_model (
	// link timebase and commands
	input wire logic i_link_clk,
	input wire logic i_go,
	input wire logic i_stop_only,
	input wire logic [6:0] i_addr,
	// switch controls from the translator
	input wire logic i_clock_pass_switch,
	input wire logic i_data_pass_switch,
	input wire logic i_data_pulldown_driver,
	// bus line levels
	output logic o_master_clock_line,
	output logic o_master_data_line,
	output logic o_slave_clock_line,
	output logic o_slave_data_line,
	// what the slave side saw, and activity
	output logic [7:0] o_seen,
	output logic o_busy
);
	logic [8:0] frame_bits;
	// isolated slave lines rest high on their pull-ups
	assign o_slave_clock_line = i_clock_pass_switch ? o_master_clock_line : 1'h1;
	assign o_slave_data_line = i_data_pulldown_driver ? 1'h0 : (i_data_pass_switch ? o_master_data_line : 1'h1);
	task automatic tick(input int k);
		repeat (k) @(i_link_clk);
	endtask
	// master frames; clock stands high between frames
	initial begin
		o_master_clock_line = 1'h1;
		o_master_data_line = 1'h1;
		o_seen = 8'h00;
		o_busy = 1'h0;
		forever begin
			@(posedge i_link_clk);
			if (i_go || i_stop_only) begin
				o_busy = 1'h1;
				if (i_go) begin
					frame_bits = {i_addr, 2'h1};
					o_master_data_line = 1'h0;
					tick(2);
					for (int b = 8; b >= 0; b--) begin
						o_master_clock_line = 1'h0;
						tick(1);
						o_master_data_line = frame_bits[b];
						tick(2);
						o_master_clock_line = 1'h1;
						tick(1);
						if (b > 0) o_seen = {o_seen[6:0], o_slave_data_line};
					end
				end
				// stop: data rises while clock high
				o_master_clock_line = 1'h0;
				tick(1);
				o_master_data_line = 1'h0;
				tick(1);
				o_master_clock_line = 1'h1;
				tick(1);
				o_master_data_line = 1'h1;
				tick(2);
				o_busy = 1'h0;
			end
		end
	end
endmodule
`default_nettype wire

// File: testbench/axt_ctrl_props.sv
// checker of the translator control outputs
`timescale 1ns/1ps
`default_nettype none
module axt_ctrl_props (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// controls
	input wire logic i_enable,
	input wire logic i_supply_undervoltage_flag,
	input wire logic i_pass_through,
	// outputs watched
	input wire logic o_clock_pass_switch,
	input wire logic o_data_pass_switch,
	input wire logic o_data_pulldown_driver,
	input wire logic o_ready,
	input wire logic [7:0] o_code_byte
);
	// ****************
	// shutdown, pass-through, reset, code byte and switch checks
	// ****************
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	logic all_off;
	// every output released and the code cleared
	assign all_off = !o_ready && !o_clock_pass_switch && !o_data_pass_switch && !o_data_pulldown_driver
		&& o_code_byte == 8'h00;
	sequence s_uv_held;
		i_supply_undervoltage_flag [*6];
	endsequence
	sequence s_en_low;
		!i_enable [*6];
	endsequence
	sequence s_pass_held;
		(i_pass_through && i_enable && !i_supply_undervoltage_flag) [*8];
	endsequence
	property p_rst_open;
		disable iff (1'h0) !i_resetn |=> !o_clock_pass_switch && !o_data_pass_switch && !o_ready;
	endproperty
	property p_uv_off;
		s_uv_held |-> all_off;
	endproperty
	property p_en_off;
		s_en_low |-> all_off;
	endproperty
	property p_lsb_zero;
		o_code_byte[0] == 1'h0;
	endproperty
	property p_ready_sw;
		o_ready |-> o_clock_pass_switch;
	endproperty
	property p_pass_closed;
		s_pass_held |-> o_clock_pass_switch && o_data_pass_switch && !o_data_pulldown_driver;
	endproperty
	property p_xlate_end;
		$fell(o_data_pass_switch) && o_clock_pass_switch |-> ##[1:1000] (o_data_pass_switch || !o_clock_pass_switch);
	endproperty
	property p_pull_disc;
		o_data_pulldown_driver |-> !o_data_pass_switch;
	endproperty
	a_rst_open: assert property (p_rst_open) else $error("switches closed after reset");
	a_uv_off: assert property (p_uv_off) else $error("outputs active under undervoltage");
	a_en_off: assert property (p_en_off) else $error("outputs active while disabled");
	a_lsb_zero: assert property (p_lsb_zero) else $error("code byte lsb set");
	a_ready_sw: assert property (p_ready_sw) else $error("ready with clock switch open");
	a_pass_closed: assert property (p_pass_closed) else $error("pass-through not closed");
	a_xlate_end: assert property (p_xlate_end) else $error("data switch stays open");
	a_pull_disc: assert property (p_pull_disc) else $error("pulldown while connected");
endmodule
bind axt_ctrl axt_ctrl_props axt_ctrl_props_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
	.i_enable(i_enable), .i_supply_undervoltage_flag(i_supply_undervoltage_flag),
	.i_pass_through(i_pass_through), .o_clock_pass_switch(o_clock_pass_switch),
	.o_data_pass_switch(o_data_pass_switch), .o_data_pulldown_driver(o_data_pulldown_driver),
	.o_ready(o_ready), .o_code_byte(o_code_byte));
`default_nettype wire

// File: testbench/axt_ctrl_tb.sv
// self-checking bench of the translator control
`timescale 1ns/1ps
`default_nettype none
module axt_ctrl_tb;
	import axt_pkg::*;
	// ****************
	// signals
	// ****************
	logic clk = 1'h0, lclk = 1'h0, resetn = 1'h0, en = 1'h1, uv = 1'h0, pass = 1'h0, go = 1'h0, stp = 1'h0;
	logic [3:0] lo = 4'h1, awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic [2:0] hi = 3'h0;
	logic [6:0] addr = 7'h00;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic mcl, mdl, scl, sdl, cps, dps, pdd, rdy, awready, wready, bvalid, arready, rvalid, busy;
	logic [7:0] code, seen;
	int fails = 0, compares = 0, n;
	// rows: low code, high code, expected code byte
	logic [15:0] rows [0:16] = '{16'h0000, 16'h1122, 16'h2244, 16'h3366, 16'h4488, 16'h55AA, 16'h66CC,
		16'h77EE, 16'h8010, 16'h9132, 16'hA254, 16'hB376, 16'hC498, 16'hD5BA, 16'hE6DC, 16'hF7FE, 16'h1002};
	// system clock and an unrelated link timebase
	always #2.5 clk = ~clk;
	always #80 lclk = ~lclk;
	axt_ctrl axt_ctrl_inst (.i_sys_clk(clk), .i_resetn(resetn), .i_low_nibble_config(lo),
		.i_high_bits_config(hi), .i_pass_through(pass), .i_enable(en), .i_supply_undervoltage_flag(uv),
		.i_master_clock_line(mcl), .i_master_data_line(mdl), .i_slave_clock_line(scl),
		.i_slave_data_line(sdl), .o_clock_pass_switch(cps), .o_data_pass_switch(dps),
		.o_data_pulldown_driver(pdd), .o_ready(rdy), .o_code_byte(code), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready));
	axt_bus_model axt_bus_model_inst (.i_link_clk(lclk), .i_go(go), .i_stop_only(stp), .i_addr(addr),
		.i_clock_pass_switch(cps), .i_data_pass_switch(dps), .i_data_pulldown_driver(pdd),
		.o_master_clock_line(mcl), .o_master_data_line(mdl), .o_slave_clock_line(scl),
		.o_slave_data_line(sdl), .o_seen(seen), .o_busy(busy));
	task automatic chk(input logic [33:0] seen_v, input logic [33:0] exp_v);
		compares++;
		if (seen_v !== exp_v) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen_v, exp_v);
		end
	endtask
	task automatic conclude;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// bounded wait on ready (sel high) or the model's busy flag
	task automatic waitb(input logic sel, input logic want, input int lim);
		n = 0;
		while ((sel ? rdy : busy) !== want && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) begin
			fails++;
			conclude();
		end
	endtask
	task automatic launch(input logic [6:0] a, input logic s);
		@(posedge clk);
		addr <= a;
		go <= !s;
		stp <= s;
		waitb(1'h0, 1'h1, 400);
		go <= 1'h0;
		stp <= 1'h0;
	endtask
	// register write: both channels offered, each dropped when taken
	task automatic axw(input logic [3:0] a, input logic [31:0] v);
		int k;
		k = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			k++;
		end while (bvalid !== 1'h1 && k < 100);
		r = bresp;
		bready <= 1'h0;
		if (k >= 100) begin
			fails++;
			conclude();
		end
	endtask
	task automatic axr(input logic [3:0] a);
		int k;
		k = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
			k++;
		end while (rvalid !== 1'h1 && k < 100);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
		if (k >= 100) begin
			fails++;
			conclude();
		end
	endtask
	// ****************
	// main sequence
	// ****************
	initial begin
		repeat (12) @(posedge clk);
		chk({cps, dps, pdd, rdy}, 4'h0);
		resetn <= 1'h1;
		waitb(1'h1, 1'h1, 30000);
		chk(n >= AXT_IDLE_CYC, 1'h1);
		chk(code, 8'h02);
		$display("power-up test done");
		axr(AXT_REG_CTRL);
		chk({r, d}, {AXT_RESP_OKAY, 32'h0});
		axr(AXT_REG_STAT);
		chk({r, d}, {AXT_RESP_OKAY, 32'h5});
		axr(AXT_REG_CODE);
		chk({r, d}, {AXT_RESP_OKAY, 32'h1});
		axr(4'hC);
		chk({r, d}, {AXT_RESP_SLVERR, 32'h0});
		axw(4'hC, 32'h1);
		chk(r, AXT_RESP_SLVERR);
		$display("register test done");
		for (int i = 0; i < 17; i++) begin
			@(posedge clk);
			lo <= rows[i][15:12];
			hi <= rows[i][10:8];
			en <= 1'h0;
			repeat (8) @(posedge clk);
			chk({rdy, code}, 9'h000);
			en <= 1'h1;
			repeat (8) @(posedge clk);
			chk(code, rows[i][7:0]);
		end
		$display("config table test done");
		launch(7'h00, 1'h1);
		waitb(1'h0, 1'h0, 400);
		waitb(1'h1, 1'h1, 400);
		launch(7'h1A, 1'h0);
		waitb(1'h0, 1'h0, 2000);
		chk(seen, 8'h36);
		$display("translation test done");
		uv <= 1'h1;
		repeat (8) @(posedge clk);
		chk({rdy, cps, dps, pdd, code}, 12'h000);
		uv <= 1'h0;
		axw(AXT_REG_CTRL, 32'h2);
		repeat (8) @(posedge clk);
		chk({r, rdy, code}, 11'h000);
		axw(AXT_REG_CTRL, 32'h0);
		launch(7'h00, 1'h1);
		waitb(1'h0, 1'h0, 400);
		waitb(1'h1, 1'h1, 400);
		chk(code, 8'h02);
		$display("shutdown test done");
		launch(7'h1A, 1'h0);
		repeat (150) @(posedge clk);
		chk(dps, 1'h0);
		pass <= 1'h1;
		hi <= 3'h7;
		repeat (8) @(posedge clk);
		chk({cps, dps, pdd}, 3'h6);
		waitb(1'h0, 1'h0, 2000);
		chk(seen, 8'h34);
		$display("pass-through test done");
		// reset in mid-run opens everything, then pass-through skips the idle wait
		resetn <= 1'h0;
		repeat (3) @(posedge clk);
		chk({cps, dps, pdd, rdy, code}, 12'h000);
		resetn <= 1'h1;
		waitb(1'h1, 1'h1, 400);
		chk({cps, dps, code}, 10'h3E2);
		$display("mid-run reset test done");
		conclude();
	end
endmodule
`default_nettype wire
